// ---- rtl/urx_map.vh ----
// Register offsets, field positions and reset values of the receive channel
`ifndef URX_MAP_VH
`define URX_MAP_VH
`define URX_OFF_DATA     12'h000
`define URX_OFF_CTRL     12'h004
`define URX_OFF_PRESCALE 12'h008
`define URX_OFF_START    12'h00C
`define URX_OFF_STOP     12'h010
`define URX_OFF_STANDBY  12'h014
`define URX_OFF_STATUS   12'h018
`define URX_DIV_LSB      9
`define URX_DIV_MSB      15
`define URX_CTRL_RXEN    0
`define URX_CTRL_NINE    1
`define URX_CTRL_ERRIE   2
`define URX_CTRL_SUPP    3
`define URX_CTRL_PAREN   4
`define URX_CTRL_PARODD  5
`define URX_ST_PAR       0
`define URX_ST_FRM       1
`define URX_ST_OVR       2
`define URX_ST_ACTIVE    3
`define URX_ST_FULL      4
`define URX_RST_DIV      7'h02
`define URX_RST_CTRL     6'h00
`define URX_RST_PS       4'h0
`endif

// ---- rtl/urx_clkdiv.v ----
// Prescaler producing the channel operating clock enable
`timescale 1ns/10ps
module urx_clkdiv (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire [3:0] sel,
  output reg        mck_en_r
);
  reg  [14:0] cnt_r;
  wire [14:0] mask;

  // Divide by two to the power sel
  assign mask = (15'h0001 << sel) - 15'h0001;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r    <= 15'h0000;
      mck_en_r <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_r + 15'h0001;
      mck_en_r <= ((cnt_r & mask) == mask);
    end
  end
endmodule // urx_clkdiv

// ---- rtl/urx_core.v ----
// Serial receive channel with stop-mode wake, APB register slave
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "urx_map.vh"
module urx_core (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_r,
  output reg         pready_r,
  output reg         pslverr_r,
  input  wire        serial_receive_pin,
  input  wire        cpu_stop,
  output reg         rx_done_irq_r,
  output reg         rx_error_irq_r,
  output reg         lowpower_receive_mode_r
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA  = 3'd2;
  localparam [2:0] ST_PAR   = 3'd3;
  localparam [2:0] ST_STOP  = 3'd4;

  reg  [1:0]  rxd_sync_r;
  reg         rxd_prev_r;
  reg  [6:0]  divisor_r;
  reg  [5:0]  ctrl_r;
  reg  [3:0]  prescale_r;
  reg         enabled_r;
  reg         standby_wake_control_r;
  reg         parity_error_flag_r;
  reg         framing_error_flag_r;
  reg         overrun_error_flag_r;
  reg         rx_full_r;
  reg  [8:0]  received_byte_field_r;
  reg  [2:0]  state_r;
  reg  [6:0]  hcnt_r;
  reg         phase_r;
  reg  [3:0]  bitcnt_r;
  reg  [8:0]  shift_r;
  reg         par_r;
  reg         suspect_r;
  reg  [31:0] prdata_nxt;
  reg         addr_ok;
  wire        mck_en;
  wire        rxd;
  wire        fall;
  wire        half_tick;
  wire        sample;
  wire        setup;
  wire        acc;
  wire        wr;
  wire        rd_data;
  wire        done_ok;
  wire        frm_err;
  wire        par_err;
  wire        ovr_err;
  wire        any_err;
  wire        suppress;
  wire [3:0]  nbits;

  urx_clkdiv u_clkdiv (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .sel      (prescale_r),
    .mck_en_r (mck_en)
  );

  assign rxd       = rxd_sync_r[1];
  assign fall      = rxd_prev_r & ~rxd;
  assign half_tick = mck_en & (hcnt_r == divisor_r);
  assign sample    = half_tick & ~phase_r;
  assign setup     = psel & ~penable;
  assign acc       = psel & penable & pready_r;
  assign wr        = acc & pwrite;
  assign rd_data   = acc & ~pwrite & (paddr == `URX_OFF_DATA);
  assign suppress  = ctrl_r[`URX_CTRL_SUPP];
  assign nbits     = ctrl_r[`URX_CTRL_NINE] ? 4'd9 : 4'd8;
  // Single stop bit checked at its centre
  assign done_ok   = (state_r == ST_STOP) & sample;
  // Start outside stop with wake control set forces framing error
  assign frm_err   = done_ok & (~rxd | suspect_r);
  assign par_err   = done_ok & ctrl_r[`URX_CTRL_PAREN] & par_r;
  assign ovr_err   = done_ok & rx_full_r & ~rd_data;
  assign any_err   = frm_err | par_err | ovr_err;

  // Receive pin passes two flops first
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_sync_r <= 2'b11;
      rxd_prev_r <= 1'b1;
    end
    else
    begin
      rxd_sync_r <= {rxd_sync_r[0], serial_receive_pin};
      rxd_prev_r <= rxd;
    end
  end

  // Register writes and channel control
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divisor_r              <= `URX_RST_DIV;
      ctrl_r                 <= `URX_RST_CTRL;
      prescale_r             <= `URX_RST_PS;
      enabled_r              <= 1'b0;
      standby_wake_control_r <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        `URX_OFF_DATA:     divisor_r <= pwdata[`URX_DIV_MSB:`URX_DIV_LSB];
        `URX_OFF_CTRL:     ctrl_r <= pwdata[5:0];
        `URX_OFF_PRESCALE: prescale_r <= pwdata[3:0];
        `URX_OFF_START:    if (pwdata[0]) enabled_r <= 1'b1;
        `URX_OFF_STOP:     if (pwdata[0]) enabled_r <= 1'b0;
        `URX_OFF_STANDBY:  standby_wake_control_r <= pwdata[0];
        default:           enabled_r <= enabled_r;
      endcase
    end
  end

  // Falling edge in stop with wake control set enters low-power state
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lowpower_receive_mode_r <= 1'b0;
    else if (~standby_wake_control_r | ~cpu_stop)
      lowpower_receive_mode_r <= 1'b0;
    else if (fall)
      lowpower_receive_mode_r <= 1'b1;
  end

  // Receive state machine
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      hcnt_r    <= 7'h00;
      phase_r   <= 1'b0;
      bitcnt_r  <= 4'h0;
      shift_r   <= 9'h000;
      par_r     <= 1'b0;
      suspect_r <= 1'b0;
    end
    else if (~enabled_r | ~ctrl_r[`URX_CTRL_RXEN])
      state_r <= ST_IDLE;
    else
    begin
      if (state_r != ST_IDLE && mck_en)
      begin
        hcnt_r <= half_tick ? 7'h00 : hcnt_r + 7'h01;
        if (half_tick)
          phase_r <= ~phase_r;
      end
      case (state_r)
        ST_IDLE:
        begin
          // Start only on falling edge of the start bit
          // In stop with wake control set, same edge starts low-power reception
          // No CPU action needed once armed
          if (fall)
          begin
            state_r   <= ST_START;
            hcnt_r    <= 7'h00;
            phase_r   <= 1'b0;
            bitcnt_r  <= 4'h0;
            par_r     <= ctrl_r[`URX_CTRL_PARODD];
            suspect_r <= standby_wake_control_r & ~cpu_stop;
          end
        end
        ST_START:
        begin
          // Too short a pulse starts no transfer
          if (half_tick)
            state_r <= rxd ? ST_IDLE : ST_DATA;
        end
        ST_DATA:
        begin
          if (sample)
          begin
            shift_r  <= {rxd, shift_r[8:1]};
            par_r    <= par_r ^ rxd;
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r == nbits - 4'h1)
              state_r <= ctrl_r[`URX_CTRL_PAREN] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR:
        begin
          if (sample)
          begin
            par_r   <= par_r ^ rxd;
            state_r <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (sample)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Data buffer, flags and interrupt pulses
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      received_byte_field_r <= 9'h000;
      rx_full_r             <= 1'b0;
      parity_error_flag_r   <= 1'b0;
      framing_error_flag_r  <= 1'b0;
      overrun_error_flag_r  <= 1'b0;
      rx_done_irq_r         <= 1'b0;
      rx_error_irq_r        <= 1'b0;
    end
    else
    begin
      // Done pulse at centre of stop bit
      rx_done_irq_r <= done_ok;
      // Enable and suppress gate the error interrupt
      rx_error_irq_r <= any_err & ctrl_r[`URX_CTRL_ERRIE] & ~suppress;
      if (done_ok)
        received_byte_field_r <= ctrl_r[`URX_CTRL_NINE] ? shift_r : {1'b0, shift_r[8:1]};
      if (done_ok)
        rx_full_r <= 1'b1;
      else if (rd_data)
        rx_full_r <= 1'b0;
      // Suppress blocks all three flags; set wins over clear
      if (par_err & ~suppress)
        parity_error_flag_r <= 1'b1;
      else if (wr && paddr == `URX_OFF_STATUS && pwdata[`URX_ST_PAR])
        parity_error_flag_r <= 1'b0;
      if (frm_err & ~suppress)
        framing_error_flag_r <= 1'b1;
      else if (wr && paddr == `URX_OFF_STATUS && pwdata[`URX_ST_FRM])
        framing_error_flag_r <= 1'b0;
      if (ovr_err & ~suppress)
        overrun_error_flag_r <= 1'b1;
      else if (wr && paddr == `URX_OFF_STATUS && pwdata[`URX_ST_OVR])
        overrun_error_flag_r <= 1'b0;
    end
  end

  // Read mux, evaluated in the setup cycle
  always @*
  begin
    prdata_nxt = 32'h00000000;
    addr_ok    = 1'b1;
    case (paddr)
      `URX_OFF_DATA:
      begin
        prdata_nxt[8:0]                       = received_byte_field_r;
        prdata_nxt[`URX_DIV_MSB:`URX_DIV_LSB] = divisor_r;
      end
      `URX_OFF_CTRL:     prdata_nxt[5:0] = ctrl_r;
      `URX_OFF_PRESCALE: prdata_nxt[3:0] = prescale_r;
      `URX_OFF_START:    prdata_nxt[0] = enabled_r;
      `URX_OFF_STOP:     prdata_nxt[0] = ~enabled_r;
      `URX_OFF_STANDBY:  prdata_nxt[0] = standby_wake_control_r;
      `URX_OFF_STATUS:
      begin
        prdata_nxt[`URX_ST_PAR]    = parity_error_flag_r;
        prdata_nxt[`URX_ST_FRM]    = framing_error_flag_r;
        prdata_nxt[`URX_ST_OVR]    = overrun_error_flag_r;
        prdata_nxt[`URX_ST_ACTIVE] = (state_r != ST_IDLE);
        prdata_nxt[`URX_ST_FULL]   = rx_full_r;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero-wait APB answer, registered
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      if (setup)
      begin
        prdata_r  <= pwrite ? 32'h00000000 : prdata_nxt;
        pslverr_r <= ~addr_ok;
      end
      else
      begin
        prdata_r  <= 32'h00000000;
        pslverr_r <= 1'b0;
      end
    end
  end
endmodule // urx_core

// ---- tb/urx_core_props.sv ----
// Port-level properties of the receive channel
`timescale 1ns/10ps
module urx_core_props (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata_r,
  input wire        pready_r,
  input wire        pslverr_r,
  input wire        cpu_stop,
  input wire        rx_done_irq_r,
  input wire        rx_error_irq_r,
  input wire        lowpower_receive_mode_r
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready_r)
    else $error("no answer after setup");
  AST_READY_CAUSE: assert property (pready_r |-> psel && penable && $past(psel) && !$past(penable))
    else $error("answer without access");
  AST_ERR_WITH_READY: assert property (pslverr_r |-> pready_r)
    else $error("error outside answer");
  AST_RDATA_IDLE: assert property (!pready_r |-> prdata_r == 32'h0)
    else $error("read data outside answer");
  AST_DONE_PULSE: assert property (rx_done_irq_r |=> !rx_done_irq_r)
    else $error("done pulse too long");
  AST_ERR_PULSE: assert property (rx_error_irq_r |=> !rx_error_irq_r)
    else $error("error pulse too long");
  AST_WAKE_NEEDS_STOP: assert property ($rose(lowpower_receive_mode_r) |-> $past(cpu_stop))
    else $error("wake outside stop");
  AST_WAKE_DROPS: assert property (!cpu_stop |=> !lowpower_receive_mode_r)
    else $error("wake state kept after stop");
  COV_DONE: cover property (rx_done_irq_r);
  COV_ERR: cover property (rx_error_irq_r);
  COV_WAKE: cover property ($rose(lowpower_receive_mode_r));
endmodule // urx_core_props

// ---- tb/urx_remote_tx.sv ----
// Remote serial transmitter model
`timescale 1ns/10ps
module urx_remote_tx #(
  parameter int BIT_CYC = 12
) (
  input  wire  clk_sys,
  output logic line
);
  initial line = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic stop_ok);
    int i;
    begin
      @(posedge clk_sys);
      line <= 1'b0;
      repeat (BIT_CYC) @(posedge clk_sys);
      for (i = 0; i < nb; i++)
      begin
        line <= d[i];
        repeat (BIT_CYC) @(posedge clk_sys);
      end
      line <= stop_ok;
      repeat (BIT_CYC) @(posedge clk_sys);
      line <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge clk_sys);
    end
  endtask
endmodule // urx_remote_tx

// ---- tb/uart_receiver_with_stop_mode_wake_bench.sv ----
// Self-checking bench for the receive channel
`timescale 1ns/10ps
`include "urx_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module uart_receiver_with_stop_mode_wake_bench;
  localparam int DIV = 5;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        rxd;
  logic        cpu_stop = 1'b0;
  logic        rx_done_irq_r;
  logic        rx_error_irq_r;
  logic        lp_mode;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          samples_checked = 0;
  int          done_cnt = 0;
  int          err_cnt = 0;
  int          lp_seen = 0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (rx_done_irq_r === 1'b1) done_cnt++;
    if (rx_error_irq_r === 1'b1) err_cnt++;
    if (lp_mode === 1'b1) lp_seen = 1;
  end
  urx_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .serial_receive_pin(rxd), .cpu_stop(cpu_stop), .rx_done_irq_r(rx_done_irq_r),
    .rx_error_irq_r(rx_error_irq_r), .lowpower_receive_mode_r(lp_mode));
  // Half bit is DIV+1 operating clocks at prescale 0
  urx_remote_tx #(.BIT_CYC(2 * (DIV + 1))) tx (.clk_sys(clk_sys), .line(rxd));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do
      begin
        @(posedge clk_sys);
      end while (pready_r !== 1'b1);
      rd = prdata_r;
      err = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic frame(input string nm, input logic [8:0] d, input int nb, input logic ok,
                       input int e_err, input logic [2:0] e_st, input logic [8:0] e_d);
    int d0;
    int e0;
    begin
      apb(1'b1, `URX_OFF_STATUS, 32'h7);
      d0 = done_cnt;
      e0 = err_cnt;
      tx.send(d, nb, ok);
      `CHK(done_cnt - d0, 1)
      `CHK(err_cnt - e0, e_err)
      apb(1'b0, `URX_OFF_STATUS, 32'h0);
      `CHK(rd[2:0], e_st)
      apb(1'b0, `URX_OFF_DATA, 32'h0);
      `CHK(rd[8:0], e_d)
      $display("Test %s done", nm);
    end
  endtask
  task automatic end_of_test;
    begin
      $display("Checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `URX_OFF_DATA, 32'h0);
    `CHK(rd[15:9], `URX_RST_DIV)
    apb(1'b0, 12'h01C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("Test reset done");
    apb(1'b1, `URX_OFF_DATA, DIV << 9);
    apb(1'b1, `URX_OFF_PRESCALE, 32'h0);
    apb(1'b1, `URX_OFF_CTRL, 32'h5);
    repeat (4) @(posedge clk_sys);
    apb(1'b1, `URX_OFF_START, 32'h1);
    frame("plain", 9'h0A5, 8, 1'b1, 0, 3'b000, 9'h0A5);
    apb(1'b1, `URX_OFF_CTRL, 32'h7);
    frame("nine", 9'h1C3, 9, 1'b1, 0, 3'b000, 9'h1C3);
    apb(1'b1, `URX_OFF_CTRL, 32'h5);
    frame("framing", 9'h03C, 8, 1'b0, 1, 3'b010, 9'h03C);
    apb(1'b1, `URX_OFF_CTRL, 32'h1);
    frame("no irq", 9'h03C, 8, 1'b0, 0, 3'b010, 9'h03C);
    // Ninth bit sent is the parity bit
    apb(1'b1, `URX_OFF_CTRL, 32'h15);
    frame("even parity", 9'h1A5, 9, 1'b1, 1, 3'b001, 9'h0A5);
    apb(1'b1, `URX_OFF_CTRL, 32'h35);
    frame("odd parity", 9'h1A5, 9, 1'b1, 0, 3'b000, 9'h0A5);
    apb(1'b1, `URX_OFF_CTRL, 32'hD);
    frame("suppress", 9'h03C, 8, 1'b0, 0, 3'b000, 9'h03C);
    apb(1'b1, `URX_OFF_CTRL, 32'h5);
    // First byte left unread
    tx.send(9'h011, 8, 1'b1);
    frame("overrun", 9'h022, 8, 1'b1, 1, 3'b100, 9'h022);
    // Flags cleared and byte read before wake control
    apb(1'b1, `URX_OFF_STATUS, 32'h7);
    apb(1'b0, `URX_OFF_DATA, 32'h0);
    `CHK(rd[8:0], 9'h022)
    apb(1'b1, `URX_OFF_STANDBY, 32'h1);
    cpu_stop <= 1'b1;
    frame("stop wake", 9'h05A, 8, 1'b1, 0, 3'b000, 9'h05A);
    `CHK(lp_seen, 1)
    cpu_stop <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(lp_mode, 1'b0)
    frame("awake", 9'h05A, 8, 1'b1, 1, 3'b010, 9'h05A);
    apb(1'b1, `URX_OFF_STANDBY, 32'h0);
    apb(1'b1, `URX_OFF_STOP, 32'h1);
    apb(1'b0, `URX_OFF_START, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("Test stop done");
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule // uart_receiver_with_stop_mode_wake_bench
bind urx_core urx_core_props chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r), .cpu_stop(cpu_stop),
  .rx_done_irq_r(rx_done_irq_r), .rx_error_irq_r(rx_error_irq_r),
  .lowpower_receive_mode_r(lowpower_receive_mode_r));
